/* File: shared/trigseq_pkg.sv */
// Constants for the trigger sequencer and storage qualifier.
// Assumes one state clock domain; event hits come from same-clock logic.
// Notes on behaviour
// - Start makes slot one the active slot.
// - Jump moves activity; inactive slot events ignored.
// - All events of active slot evaluated together.
// - Slot without jump stays active until stop.
// - Empty active slot does nothing; acquisition continues.
// - Fallback-only slot fires fallback every step.
// - All true events fire commands same step.
// - Conflicts resolved: earlier clause wins.
// - Only conflicting bracket member is dropped.
// - Conflicts: different jump targets, different ops on same counter.
// - Conflict inside one bracket is an error.
// - Error marks first contradiction line and flag.
// - Start refused while contradiction exists.
// - At most one qualification block.
// - Qualification condition: OR of maybe-inverted events.
// - Qualified mode stores only when condition or a store command is true.
// - Qualification block ignores active slot.
// - Store command counts only when executed.
// - No qualification anywhere: store every sample.
// - Otherwise store on command OR block condition.
// - Up to four slots in program order.
// - Exactly one slot active at any time.
// - Fallback fires when no event true.
package trigseq_pkg;
    localparam int NUM_SLOTS    = 4;
    localparam int NUM_CLAUSES  = 4;
    localparam int NUM_EVENTS   = 8;
    localparam int NUM_COUNTERS = 2;
    localparam int SLOT_W       = 2;
    localparam int CLAUSE_W     = 2;
    localparam int CNT_ID_W     = 1;
    localparam int CNT_OP_W     = 2;
    localparam int FIFO_DEPTH   = 16;
    // Clause word field positions
    localparam int F_VALID      = 0;
    localparam int F_ELSE       = 1;
    localparam int F_CONT       = 2;
    localparam int F_MASK       = 3;
    localparam int F_INV        = 11;
    localparam int F_JUMP       = 19;
    localparam int F_TGT        = 20;
    localparam int F_CNT        = 22;
    localparam int F_CNT_ID     = 23;
    localparam int F_CNT_OP     = 24;
    localparam int F_TRIG       = 26;
    localparam int F_STORE      = 27;
    localparam int WORD_W       = 28;
    localparam logic [SLOT_W-1:0] FIRST_SLOT = 2'h0;
    typedef enum logic [1:0] {CNT_INC = 2'h0, CNT_RESET = 2'h1, CNT_RESET_RUN = 2'h2, CNT_STOP = 2'h3} cnt_op_type;
    typedef enum logic [1:0] {RUN_IDLE = 2'h0, RUN_ACTIVE = 2'h1} run_state_type;
endpackage : trigseq_pkg

/* File: src/trigger_sequencer_qualifier.sv */
// Trigger sequencer, storage qualifier and sample FIFO.
// Assumes event hits are same-clock logic and FIFO depth is a power of two.
`timescale 1ns/1ns

module store_fifo
    import trigseq_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wp_q;
    logic [PTR_W-1:0] rp_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             ready_q;
    logic             ov_q;
    logic [WIDTH-1:0] od_q;
    logic             wr;
    logic             load;

    assign wr    = in_valid_i && ready_q;
    assign load  = (cnt_q != '0) && (!ov_q || out_ready_i);
    assign cnt_d = cnt_q + CNT_W'(wr) - CNT_W'(load);
    assign in_ready_o  = ready_q;
    assign out_valid_o = ov_q;
    assign out_data_o  = od_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (wr)
        begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wp_q    <= '0;
            rp_q    <= '0;
            cnt_q   <= '0;
            ready_q <= 1'b1;
        end
        else
        begin
            wp_q    <= wr ? wp_q + PTR_W'(1) : wp_q;
            rp_q    <= load ? rp_q + PTR_W'(1) : rp_q;
            cnt_q   <= cnt_d;
            ready_q <= cnt_d != CNT_W'(DEPTH);
        end
    end

    // Output stage lets the drain side stall
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ov_q <= 1'b0;
            od_q <= '0;
        end
        else if (load)
        begin
            ov_q <= 1'b1;
            od_q <= mem_q[rp_q];
        end
        else if (out_ready_i)
        begin
            ov_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    property p_fifo_full;
        cnt_q == CNT_W'(DEPTH) |-> !in_ready_o;
    endproperty
    a_fifo_full: assert property (p_fifo_full) else $error("fifo full but ready");
    c_fifo_full: cover property (cnt_q == CNT_W'(DEPTH));
endmodule : store_fifo

module trigger_sequencer_qualifier
    import trigseq_pkg::*;
#(
    parameter int DATA_W = 16
)(
    input  wire logic                       clk_sys_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       prog_we_i,
    input  wire logic [SLOT_W-1:0]          prog_slot_i,
    input  wire logic [CLAUSE_W-1:0]        prog_clause_i,
    input  wire logic [WORD_W-1:0]          prog_word_i,
    input  wire logic                       qual_present_i,
    input  wire logic [NUM_EVENTS-1:0]      qual_mask_i,
    input  wire logic [NUM_EVENTS-1:0]      qual_inv_i,
    input  wire logic                       start_i,
    input  wire logic                       stop_i,
    input  wire logic                       sample_valid_i,
    input  wire logic [DATA_W-1:0]          sample_data_i,
    input  wire logic [NUM_EVENTS-1:0]      event_hit_i,
    output logic                            sample_ready_o,
    output logic                            acq_valid_o,
    output logic [DATA_W-1:0]               acq_data_o,
    input  wire logic                       acq_ready_i,
    output logic                            running_o,
    output logic [SLOT_W-1:0]               active_slot_o,
    output logic                            trigger_o,
    output logic                            jump_o,
    output logic [NUM_COUNTERS-1:0]         cnt_cmd_o,
    output logic [NUM_COUNTERS*CNT_OP_W-1:0] cnt_op_o,
    output logic                            contra_o,
    output logic [SLOT_W-1:0]               contra_slot_o,
    output logic [CLAUSE_W-1:0]             contra_clause_o,
    output logic                            run_refused_o
);
    logic [WORD_W-1:0]              prog_mem_q [NUM_SLOTS][NUM_CLAUSES];
    run_state_type                  state_q;
    logic [SLOT_W-1:0]              active_slot_q;
    logic                           trig_q;
    logic                           jump_q;
    logic [NUM_COUNTERS-1:0]        cnt_cmd_q;
    logic [NUM_COUNTERS*CNT_OP_W-1:0] cnt_op_q;
    logic                           contra_q;
    logic [SLOT_W-1:0]              cslot_q;
    logic [CLAUSE_W-1:0]            cclause_q;
    logic                           refused_q;
    logic [WORD_W-1:0]              word_w [NUM_CLAUSES];
    logic [NUM_CLAUSES-1:0]         hit_w;
    logic [NUM_CLAUSES-1:0]         fire_c;
    logic                           any_hit_c;
    logic                           jump_fire_c;
    logic [SLOT_W-1:0]              jump_tgt_c;
    logic                           trig_c;
    logic                           store_cmd_c;
    logic [NUM_COUNTERS-1:0]        cnt_en_c;
    logic [NUM_COUNTERS*CNT_OP_W-1:0] cnt_op_c;
    logic                           contra_c;
    logic [SLOT_W-1:0]              cslot_c;
    logic [CLAUSE_W-1:0]            cclause_c;
    logic                           store_any_c;
    logic                           linked_c;
    logic                           running;
    logic                           fifo_ready;
    logic                           step;
    logic                           qual_hit;
    logic                           qual_used;
    logic                           push;

    assign running        = state_q == RUN_ACTIVE;
    assign step           = running && sample_valid_i && fifo_ready;
    assign sample_ready_o = fifo_ready;
    assign running_o      = running;
    assign active_slot_o  = active_slot_q;
    assign trigger_o      = trig_q;
    assign jump_o         = jump_q;
    assign cnt_cmd_o      = cnt_cmd_q;
    assign cnt_op_o       = cnt_op_q;
    assign contra_o       = contra_q;
    assign contra_slot_o  = cslot_q;
    assign contra_clause_o = cclause_q;
    assign run_refused_o  = refused_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (prog_we_i && !running)
        begin
            prog_mem_q[prog_slot_i][prog_clause_i] <= prog_word_i;
        end
    end

    for (genvar c = 0; c < NUM_CLAUSES; c++)
    begin : g_clause
        assign word_w[c] = prog_mem_q[active_slot_q][c];
        assign hit_w[c]  = word_w[c][F_VALID] && !word_w[c][F_ELSE] && !word_w[c][F_CONT]
                           && |((event_hit_i ^ word_w[c][F_INV+:NUM_EVENTS]) & word_w[c][F_MASK+:NUM_EVENTS]);
    end

    always_comb
    begin
        any_hit_c = |hit_w;
        for (int c = 0; c < NUM_CLAUSES; c++)
        begin
            if (c > 0 && word_w[c][F_CONT])
                fire_c[c] = fire_c[(c > 0) ? c - 1 : 0] && word_w[c][F_VALID];
            else if (word_w[c][F_ELSE])
                fire_c[c] = word_w[c][F_VALID] && !any_hit_c;
            else
                fire_c[c] = hit_w[c];
        end
    end

    always_comb
    begin
        jump_fire_c = 1'b0;
        jump_tgt_c  = FIRST_SLOT;
        trig_c      = 1'b0;
        store_cmd_c = 1'b0;
        cnt_en_c    = '0;
        cnt_op_c    = '0;
        for (int c = 0; c < NUM_CLAUSES; c++)
        begin
            if (fire_c[c])
            begin
                if (word_w[c][F_JUMP] && !jump_fire_c)
                begin
                    jump_fire_c = 1'b1;
                    jump_tgt_c  = word_w[c][F_TGT+:SLOT_W];
                end
                if (word_w[c][F_CNT] && !cnt_en_c[word_w[c][F_CNT_ID+:CNT_ID_W]])
                begin
                    cnt_en_c[word_w[c][F_CNT_ID+:CNT_ID_W]] = 1'b1;
                    cnt_op_c[word_w[c][F_CNT_ID+:CNT_ID_W]*CNT_OP_W+:CNT_OP_W] = word_w[c][F_CNT_OP+:CNT_OP_W];
                end
                trig_c      = trig_c | word_w[c][F_TRIG];
                store_cmd_c = store_cmd_c | word_w[c][F_STORE];
            end
        end
    end

    always_comb
    begin
        contra_c    = 1'b0;
        cslot_c     = '0;
        cclause_c   = '0;
        store_any_c = 1'b0;
        linked_c    = 1'b0;
        for (int s = 0; s < NUM_SLOTS; s++)
        begin
            for (int j = 0; j < NUM_CLAUSES; j++)
            begin
                store_any_c = store_any_c | (prog_mem_q[s][j][F_VALID] && prog_mem_q[s][j][F_STORE]);
                linked_c = 1'b1;
                for (int i = NUM_CLAUSES - 2; i >= 0; i--)
                begin
                    if (i < j)
                    begin
                        linked_c = linked_c && prog_mem_q[s][i+1][F_CONT];
                        if (linked_c && !contra_c && prog_mem_q[s][i][F_VALID] && prog_mem_q[s][j][F_VALID]
                            && ((prog_mem_q[s][i][F_JUMP] && prog_mem_q[s][j][F_JUMP]
                                 && prog_mem_q[s][i][F_TGT+:SLOT_W] != prog_mem_q[s][j][F_TGT+:SLOT_W])
                             || (prog_mem_q[s][i][F_CNT] && prog_mem_q[s][j][F_CNT]
                                 && prog_mem_q[s][i][F_CNT_ID+:CNT_ID_W] == prog_mem_q[s][j][F_CNT_ID+:CNT_ID_W]
                                 && prog_mem_q[s][i][F_CNT_OP+:CNT_OP_W] != prog_mem_q[s][j][F_CNT_OP+:CNT_OP_W])))
                        begin
                            contra_c  = 1'b1;
                            cslot_c   = SLOT_W'(s);
                            cclause_c = CLAUSE_W'(j);
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            contra_q  <= 1'b0;
            cslot_q   <= '0;
            cclause_q <= '0;
        end
        else
        begin
            contra_q  <= contra_c;
            cslot_q   <= cslot_c;
            cclause_q <= cclause_c;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q       <= RUN_IDLE;
            active_slot_q <= FIRST_SLOT;
            refused_q     <= 1'b0;
        end
        else
        begin
            refused_q <= 1'b0;
            case (state_q)
                RUN_IDLE:
                begin
                    if (start_i && contra_q)
                        refused_q <= 1'b1;
                    else if (start_i)
                    begin
                        state_q       <= RUN_ACTIVE;
                        active_slot_q <= FIRST_SLOT;
                    end
                end
                RUN_ACTIVE:
                begin
                    if (stop_i)
                        state_q <= RUN_IDLE;
                    else if (step && jump_fire_c)
                        active_slot_q <= jump_tgt_c;
                end
                default:
                    state_q <= RUN_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            trig_q    <= 1'b0;
            jump_q    <= 1'b0;
            cnt_cmd_q <= '0;
            cnt_op_q  <= '0;
        end
        else
        begin
            trig_q    <= step && trig_c;
            jump_q    <= step && jump_fire_c;
            cnt_cmd_q <= step ? cnt_en_c : '0;
            cnt_op_q  <= cnt_op_c;
        end
    end

    assign qual_hit  = qual_present_i && |((event_hit_i ^ qual_inv_i) & qual_mask_i);
    assign qual_used = qual_present_i || store_any_c;
    assign push = step && (!qual_used || store_cmd_c || qual_hit);

    store_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (push),
        .in_data_i   (sample_data_i),
        .in_ready_o  (fifo_ready),
        .out_valid_o (acq_valid_o),
        .out_data_o  (acq_data_o),
        .out_ready_i (acq_ready_i)
    );

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    property p_start;
        !running && start_i && !contra_q |=> running && active_slot_q == FIRST_SLOT;
    endproperty
    a_start: assert property (p_start) else $error("start did not select slot one");
    property p_jump;
        running && !stop_i && step && jump_fire_c |=> active_slot_q == $past(jump_tgt_c) && jump_o;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target not taken");
    property p_hold;
        running && !(step && jump_fire_c) |=> $stable(active_slot_q);
    endproperty
    a_hold: assert property (p_hold) else $error("slot changed without jump");
    property p_refuse;
        !running && start_i && contra_q |=> !running && run_refused_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("run entered with contradiction");
    property p_store_all;
        step && !qual_used |-> push;
    endproperty
    a_store_all: assert property (p_store_all) else $error("unqualified sample dropped");
    property p_store_or;
        step && qual_used |-> push == (store_cmd_c || qual_hit);
    endproperty
    a_store_or: assert property (p_store_or) else $error("qualified store mismatch");
    property p_trig;
        step && trig_c |=> trigger_o;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger not issued");
    property p_idle;
        !running |=> !trigger_o && !jump_o && cnt_cmd_o == '0;
    endproperty
    a_idle: assert property (p_idle) else $error("command while idle");
    c_jump: cover property (step && jump_fire_c);
    c_refuse: cover property (run_refused_o);
    c_qual: cover property (step && qual_used && push);
endmodule : trigger_sequencer_qualifier

/* File: bench/sample_source.sv */
// Sample source model for the traced processor bus.
// Assumes the bench clock; holds each sample until the sequencer takes it.
`timescale 1ns/1ns

module sample_source
    import trigseq_pkg::*;
#(
    parameter int DATA_W = 16
)(
    input  wire logic                  clk_sys_i,
    input  wire logic                  sample_ready_i,
    output logic                       sample_valid_o,
    output logic [DATA_W-1:0]          sample_data_o,
    output logic [NUM_EVENTS-1:0]      event_hit_o
);
    initial
    begin
        sample_valid_o = 1'b0;
        sample_data_o  = '0;
        event_hit_o    = '0;
    end

    // Offers one sample after an optional stall and holds it until taken
    task automatic send(input logic [DATA_W-1:0] d, input logic [NUM_EVENTS-1:0] ev, input int stall);
        int n;
        n = 0;
        repeat (stall) @(negedge clk_sys_i);
        @(negedge clk_sys_i);
        sample_valid_o = 1'b1;
        sample_data_o  = d;
        event_hit_o    = ev;
        @(posedge clk_sys_i);
        while (sample_ready_i !== 1'b1 && n < 200)
        begin
            n++;
            @(posedge clk_sys_i);
        end
        @(negedge clk_sys_i);
        // Released lines show the inverse so stale values never look live
        sample_valid_o = 1'b0;
        sample_data_o  = ~d;
        event_hit_o    = ~ev;
    endtask : send
endmodule : sample_source

/* File: bench/tb_trigger_sequencer_qualifier.sv */
// Bench for the trigger sequencer: loads slot programs, runs samples, checks pulses and stored data.
// Assumes the design package and the sample source model are compiled first.
`timescale 1ns/1ns

module tb_trigger_sequencer_qualifier
    import trigseq_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic prog_we_i = 1'b0;
    logic [SLOT_W-1:0] prog_slot_i = '0;
    logic [CLAUSE_W-1:0] prog_clause_i = '0;
    logic [WORD_W-1:0] prog_word_i = '0;
    logic qual_present_i = 1'b0;
    logic [NUM_EVENTS-1:0] qual_mask_i = '0;
    logic [NUM_EVENTS-1:0] qual_inv_i = '0;
    logic start_i = 1'b0;
    logic stop_i = 1'b0;
    logic acq_ready_i = 1'b1;
    logic sample_valid_i, sample_ready_o, acq_valid_o, running_o, trigger_o, jump_o, contra_o, run_refused_o;
    logic [15:0] sample_data_i, acq_data_o;
    logic [NUM_EVENTS-1:0] event_hit_i;
    logic [SLOT_W-1:0] active_slot_o, contra_slot_o;
    logic [CLAUSE_W-1:0] contra_clause_o;
    logic [NUM_COUNTERS-1:0] cnt_cmd_o;
    logic [NUM_COUNTERS*CNT_OP_W-1:0] cnt_op_o;
    logic [WORD_W-1:0] pg [16];
    logic [15:0] got_q [$];
    int miscompares = 0;
    int n_checks = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    trigger_sequencer_qualifier u_trigger_sequencer_qualifier (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .prog_we_i(prog_we_i), .prog_slot_i(prog_slot_i),
        .prog_clause_i(prog_clause_i), .prog_word_i(prog_word_i), .qual_present_i(qual_present_i),
        .qual_mask_i(qual_mask_i), .qual_inv_i(qual_inv_i), .start_i(start_i), .stop_i(stop_i),
        .sample_valid_i(sample_valid_i), .sample_data_i(sample_data_i), .event_hit_i(event_hit_i),
        .sample_ready_o(sample_ready_o), .acq_valid_o(acq_valid_o), .acq_data_o(acq_data_o),
        .acq_ready_i(acq_ready_i), .running_o(running_o), .active_slot_o(active_slot_o),
        .trigger_o(trigger_o), .jump_o(jump_o), .cnt_cmd_o(cnt_cmd_o), .cnt_op_o(cnt_op_o),
        .contra_o(contra_o), .contra_slot_o(contra_slot_o), .contra_clause_o(contra_clause_o),
        .run_refused_o(run_refused_o));

    sample_source u_sample_source (
        .clk_sys_i(clk_sys_i), .sample_ready_i(sample_ready_o), .sample_valid_o(sample_valid_i),
        .sample_data_o(sample_data_i), .event_hit_o(event_hit_i));

    always @(posedge clk_sys_i)
        if (acq_valid_o === 1'b1 && acq_ready_i === 1'b1)
            got_q.push_back(acq_data_o);

    function automatic logic [WORD_W-1:0] bt(input int p);
        bt = '0;
        bt[p] = 1'b1;
    endfunction : bt

    function automatic logic [WORD_W-1:0] ev(input logic [7:0] m);
        ev = bt(F_VALID);
        ev[F_MASK +: 8] = m;
    endfunction : ev

    function automatic logic [WORD_W-1:0] jmp(input logic [1:0] t);
        jmp = bt(F_JUMP);
        jmp[F_TGT +: 2] = t;
    endfunction : jmp

    function automatic logic [WORD_W-1:0] cnt(input logic k, input logic [1:0] op);
        cnt = bt(F_CNT);
        cnt[F_CNT_ID] = k;
        cnt[F_CNT_OP +: 2] = op;
    endfunction : cnt

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic pulses(input logic t, input logic j, input logic [1:0] s);
        chk(trigger_o, t);
        chk(jump_o, j);
        chk(active_slot_o, s);
    endtask : pulses

    task automatic smp(input logic [15:0] d, input logic [7:0] e);
        u_sample_source.send(d, e, int'(d[0]));
    endtask : smp

    // Stops any run, then writes all sixteen clause words
    task automatic load();
        @(negedge clk_sys_i);
        stop_i = 1'b1;
        @(negedge clk_sys_i);
        stop_i = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            @(negedge clk_sys_i);
            prog_we_i = 1'b1;
            prog_slot_i = i[3:2];
            prog_clause_i = i[1:0];
            prog_word_i = pg[i];
        end
        @(negedge clk_sys_i);
        prog_we_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
    endtask : load

    task automatic go();
        got_q.delete();
        @(negedge clk_sys_i);
        start_i = 1'b1;
        @(negedge clk_sys_i);
        start_i = 1'b0;
    endtask : go

    task automatic expect_stored(input logic [15:0] exp [$]);
        repeat (4) @(negedge clk_sys_i);
        chk(got_q.size(), exp.size());
        foreach (exp[i])
            if (i < got_q.size())
                chk(got_q[i], exp[i]);
        got_q.delete();
    endtask : expect_stored

    task automatic s_sequence();
        pg = '{default: '0};
        pg[0] = ev(8'h01) | jmp(2'h1);
        pg[4] = ev(8'h02) | bt(F_TRIG);
        load();
        go();
        chk(running_o, 1'b1);
        chk(active_slot_o, 2'h0);
        smp(16'h0010, 8'h02);
        pulses(1'b0, 1'b0, 2'h0);
        smp(16'h0011, 8'h03);
        pulses(1'b0, 1'b1, 2'h1);
        smp(16'h0012, 8'h01);
        pulses(1'b0, 1'b0, 2'h1);
        smp(16'h0013, 8'h02);
        pulses(1'b1, 1'b0, 2'h1);
    endtask : s_sequence

    task automatic s_conflict();
        pg = '{default: '0};
        pg[0] = ev(8'h01) | jmp(2'h2) | cnt(1'b0, CNT_INC);
        pg[1] = ev(8'h02) | jmp(2'h3);
        pg[2] = bt(F_VALID) | bt(F_CONT) | bt(F_TRIG) | cnt(1'b0, CNT_RESET);
        pg[3] = ev(8'h04) | cnt(1'b1, CNT_STOP);
        load();
        go();
        chk(contra_o, 1'b0);
        smp(16'h0020, 8'h07);
        pulses(1'b1, 1'b1, 2'h2);
        chk(cnt_cmd_o, 2'h3);
        chk(cnt_op_o, {CNT_STOP, CNT_INC});
        smp(16'h0021, 8'hFF);
        pulses(1'b0, 1'b0, 2'h2);
        chk(cnt_cmd_o, 2'h0);
        expect_stored('{16'h0020, 16'h0021});
    endtask : s_conflict

    task automatic s_contra();
        pg = '{default: '0};
        pg[0] = ev(8'h01) | cnt(1'b0, CNT_INC);
        pg[1] = bt(F_VALID) | bt(F_CONT) | cnt(1'b0, CNT_RESET);
        pg[8] = ev(8'h01) | jmp(2'h0);
        pg[9] = bt(F_VALID) | bt(F_CONT) | jmp(2'h1);
        load();
        chk(contra_o, 1'b1);
        chk({contra_slot_o, contra_clause_o}, 4'h1);
        go();
        chk(run_refused_o, 1'b1);
        chk(running_o, 1'b0);
    endtask : s_contra

    task automatic s_fallback();
        pg = '{default: '0};
        pg[0] = bt(F_VALID) | bt(F_ELSE) | bt(F_TRIG);
        load();
        go();
        smp(16'h0030, 8'h00);
        pulses(1'b1, 1'b0, 2'h0);
        smp(16'h0031, 8'hFF);
        pulses(1'b1, 1'b0, 2'h0);
    endtask : s_fallback

    task automatic s_store();
        pg = '{default: '0};
        load();
        go();
        smp(16'h0040, 8'h00);
        smp(16'h0041, 8'hFF);
        expect_stored('{16'h0040, 16'h0041});
        qual_present_i = 1'b1;
        qual_mask_i = 8'h04;
        pg[0] = ev(8'h01) | jmp(2'h3) | bt(F_STORE);
        load();
        go();
        smp(16'h00A1, 8'h04);
        smp(16'h00A2, 8'h00);
        smp(16'h00A3, 8'h01);
        chk(active_slot_o, 2'h3);
        smp(16'h00A4, 8'h01);
        smp(16'h00A5, 8'h04);
        expect_stored('{16'h00A1, 16'h00A3, 16'h00A5});
        qual_mask_i = 8'h0C;
        qual_inv_i = 8'h08;
        pg = '{default: '0};
        load();
        go();
        smp(16'h00B1, 8'h08);
        smp(16'h00B2, 8'h00);
        smp(16'h00B3, 8'h0C);
        expect_stored('{16'h00B2, 16'h00B3});
        qual_present_i = 1'b0;
    endtask : s_store

    // Fills the buffer with the sink stalled, then drains it in order
    task automatic s_fifo();
        int n;
        logic [15:0] e [$];
        pg = '{default: '0};
        load();
        go();
        acq_ready_i = 1'b0;
        n = 0;
        while (n < 30 && sample_ready_o === 1'b1)
        begin
            smp(n[15:0], 8'h00);
            e.push_back(n[15:0]);
            n++;
        end
        chk(n, FIFO_DEPTH + 1);
        acq_ready_i = 1'b1;
        repeat (24) @(negedge clk_sys_i);
        expect_stored(e);
        chk(acq_valid_o, 1'b0);
        chk(sample_ready_o, 1'b1);
    endtask : s_fifo

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        @(negedge clk_sys_i);
        // Program store is unset until loaded, so the contradiction flag is only known during reset
        chk({running_o, sample_ready_o, acq_valid_o, trigger_o, contra_o, active_slot_o}, 7'h20);
        @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        @(negedge clk_sys_i);
        chk({running_o, sample_ready_o, acq_valid_o, trigger_o, active_slot_o}, 6'h10);
        s_sequence();
        s_conflict();
        s_contra();
        s_fallback();
        s_store();
        s_fifo();
        report_and_stop();
    end
endmodule : tb_trigger_sequencer_qualifier
